// >>> design/e1_rx_status_capture.sv
// Purpose: E1 receive status bank on APB, read-only except the line-loss threshold select
// Assumes: framer strobes share CLOCK_I; LOS comparator is asynchronous
// Notes: zero-wait APB slave; unmapped addresses answer with PSLVERR
`timescale 1ns/1ps
`include "e1_rx_status_params.svh"
module e1_rx_status_capture #(
  parameter int FRAME_CYCLES = `FRAME_CYC,
  parameter int LOS_CYCLES = `LOS_CYC,
  parameter int JFIFO_DEPTH = `JFIFO_DEPTH
) (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // receive path strobes
  input wire logic SLIP_I,
  input wire logic SLIP_REPEAT_I,
  input wire e1_rx_status_pkg::phase_t PHASE_I,
  input wire logic RX_BIT_I,
  input wire logic RX_BIT_VALID_I,
  input wire e1_rx_status_pkg::ts0_t TS0_I,
  // line interface and jitter attenuator
  input wire logic LOS_BELOW_I,
  output logic LOS_THRESH_SEL_O,
  input wire logic DJ_SLOW_I,
  input wire logic DJ_FAST_I,
  input wire logic [$clog2(JFIFO_DEPTH+1)-1:0] JFIFO_LEVEL_I
);
  localparam int LW = $clog2(JFIFO_DEPTH+1);
  localparam int FW = $clog2(FRAME_CYCLES);
  localparam int OW = $clog2(LOS_CYCLES+1);

  // refuse sizes the counters and flags cannot serve
  if (JFIFO_DEPTH < 2 * `JFIFO_FOUR || FRAME_CYCLES < 2 ||
      LOS_CYCLES < 1) begin : g_bad_param
    $error("e1_rx_status_capture: bad parameter");
  end

  //////////////////////////////////////////////////////////////////////////
  // register decode

  // maps a byte address to a register index, 5'h00 when unmapped
  function automatic logic [4:0] idx_of(input logic [7:0] a);
    logic [4:0] i;
    i = a[6:2];
    if (a[1:0] != 2'h0 || a[7])
      idx_of = 5'h00;
    else if ((i >= `IDX_SLIP_HIGH && i <= `IDX_NONALIGN) ||
             i == `IDX_LOS_CTRL)
      idx_of = i;
    else
      idx_of = 5'h00;
  endfunction

  logic slip_tog_r;
  logic slip_dir_r;
  logic frm_dly_r;
  logic alt_flag_r;
  logic frm_tog_r;
  logic [2:0] sub_dly_r;
  logic [7:0] slip_high;
  logic [7:0] phase_low_r;
  logic [7:0] align_r;
  logic [7:0] line_sig_r;
  logic [7:0] dejit_r;
  logic [7:0] nonalign_r;
  logic los_sel_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [7:0] rd_nxt;
  logic setup;
  logic done;

  assign setup = PSEL_I && !PENABLE_I;
  assign done = PSEL_I && PENABLE_I && pready_r;

  // high phase word gathered from one register per concern
  assign slip_high = {slip_tog_r, slip_dir_r, frm_dly_r, alt_flag_r,
                      frm_tog_r, sub_dly_r};

  //////////////////////////////////////////////////////////////////////////
  // apb slave

  // read mux; bits not listed in a register read as zero
  always_comb begin
    case (idx_of(PADDR_I))
      `IDX_SLIP_HIGH: rd_nxt = slip_high;
      `IDX_PHASE_LOW: rd_nxt = phase_low_r;
      `IDX_ALIGN_CAP: rd_nxt = align_r;
      `IDX_LINE_SIG: rd_nxt = line_sig_r;
      `IDX_DEJITTER: rd_nxt = dejit_r;
      `IDX_NONALIGN: rd_nxt = nonalign_r;
      `IDX_LOS_CTRL: rd_nxt = {7'h00, los_sel_r};
      default: rd_nxt = 8'h00;
    endcase
  end

  // answer one cycle after setup, so every access is zero-wait
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else if (setup) begin
      pready_r <= 1'b1;
      pslverr_r <= (idx_of(PADDR_I) == 5'h00);
      prdata_r <= PWRITE_I ? 32'h0000_0000 : {24'h00_0000, rd_nxt};
    end else begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  // status writes dropped
  // only the line-loss threshold select accepts writes
  always_ff @(posedge CLOCK_I) begin
    if (RST_I)
      los_sel_r <= 1'b0;
    else if (done && PWRITE_I && idx_of(PADDR_I) == `IDX_LOS_CTRL)
      los_sel_r <= PWDATA_I[0];
  end

  assign PRDATA_O = prdata_r;
  assign PREADY_O = pready_r;
  assign PSLVERR_O = pslverr_r;
  assign LOS_THRESH_SEL_O = los_sel_r;

  //////////////////////////////////////////////////////////////////////////
  // slips and buffer phase

  logic [FW-1:0] frame_cnt_r;
  logic frame_tick;

  always_ff @(posedge CLOCK_I) begin
    if (RST_I)
      frame_cnt_r <= '0;
    else if (frame_cnt_r == FW'(FRAME_CYCLES - 1))
      frame_cnt_r <= '0;
    else
      frame_cnt_r <= frame_cnt_r + FW'(1);
  end
  assign frame_tick = (frame_cnt_r == FW'(FRAME_CYCLES - 1));

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      slip_tog_r <= 1'b0;
      slip_dir_r <= 1'b0;
    end else if (SLIP_I) begin
      slip_tog_r <= ~slip_tog_r;
      slip_dir_r <= SLIP_REPEAT_I;
    end
  end

  // phase sample once a frame keeps the pair coherent for software
  // phase word sample
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      frm_dly_r <= 1'b0;
      sub_dly_r <= 3'h0;
      phase_low_r <= 8'h00;
    end else if (frame_tick) begin
      frm_dly_r <= PHASE_I.frame_delay_msb;
      sub_dly_r <= PHASE_I.sub_bit_delay;
      phase_low_r <= {PHASE_I.slot_offset_count,
                      PHASE_I.bit_offset_count};
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I)
      frm_tog_r <= 1'b0;
    else if (frame_tick && phase_low_r[7] &&
             !PHASE_I.slot_offset_count[4])
      frm_tog_r <= ~frm_tog_r;
  end

  //////////////////////////////////////////////////////////////////////////
  // alternating pattern detector

  e1_rx_status_pkg::alt_state_t alt_st_r;
  logic [9:0] alt_run_r;
  logic [8:0] alt_win_r;
  logic [1:0] alt_err_r;
  logic alt_exp_r;
  logic alt_miss;

  assign alt_miss = (RX_BIT_I != alt_exp_r);

  // run with bounded errors
  // a flip costs one error: the expected bit toggles on its own
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      alt_st_r <= e1_rx_status_pkg::ALT_IDLE;
      alt_run_r <= 10'h000;
      alt_win_r <= 9'h000;
      alt_err_r <= 2'h0;
      alt_exp_r <= 1'b0;
    end else if (RX_BIT_VALID_I) begin
      alt_exp_r <= ~RX_BIT_I;
      alt_win_r <= alt_win_r + 9'h001;
      case (alt_st_r)
        e1_rx_status_pkg::ALT_IDLE: begin
          alt_st_r <= e1_rx_status_pkg::ALT_RUN;
          alt_run_r <= 10'h001;
          alt_win_r <= 9'h001;
          alt_err_r <= 2'h0;
        end
        e1_rx_status_pkg::ALT_RUN,
        e1_rx_status_pkg::ALT_FOUND: begin
          if (alt_miss && alt_err_r == 2'(`ALT_ERR_MAX)) begin
            alt_st_r <= e1_rx_status_pkg::ALT_IDLE;
            alt_run_r <= 10'h000;
          end else begin
            if (alt_miss)
              alt_err_r <= alt_err_r + 2'h1;
            else if (alt_win_r == 9'h1FF)
              alt_err_r <= 2'h0;
            alt_exp_r <= ~alt_exp_r;
            if (alt_run_r != 10'(`ALT_RUN_BITS))
              alt_run_r <= alt_run_r + 10'h001;
            if (alt_run_r == 10'(`ALT_RUN_BITS - 1))
              alt_st_r <= e1_rx_status_pkg::ALT_FOUND;
          end
        end
        default: alt_st_r <= e1_rx_status_pkg::ALT_IDLE;
      endcase
    end
  end

  // flag registered from state, one cycle behind it
  always_ff @(posedge CLOCK_I) begin
    if (RST_I)
      alt_flag_r <= 1'b0;
    else
      alt_flag_r <= (alt_st_r == e1_rx_status_pkg::ALT_FOUND);
  end

  //////////////////////////////////////////////////////////////////////////
  // timeslot zero capture

  always_ff @(posedge CLOCK_I) begin
    if (RST_I)
      align_r <= 8'h00;
    else if (TS0_I.valid && TS0_I.is_align)
      align_r <= TS0_I.data;
  end

  // alternate frames
  // marker bit is kept as received so software sees a bad far end
  always_ff @(posedge CLOCK_I) begin
    if (RST_I)
      nonalign_r <= 8'h00;
    else if (TS0_I.valid && !TS0_I.is_align)
      nonalign_r <= TS0_I.data;
  end

  //////////////////////////////////////////////////////////////////////////
  // line loss of signal

  logic los_s1_r;
  logic los_s2_r;
  logic [OW-1:0] los_cnt_r;

  // two-flop synchroniser for the analog comparator
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      los_s1_r <= 1'b0;
      los_s2_r <= 1'b0;
    end else begin
      los_s1_r <= LOS_BELOW_I;
      los_s2_r <= los_s1_r;
    end
  end

  // one millisecond qualify
  // any glitch above threshold restarts the full wait
  always_ff @(posedge CLOCK_I) begin
    if (RST_I)
      los_cnt_r <= '0;
    else if (!los_s2_r)
      los_cnt_r <= '0;
    else if (los_cnt_r != OW'(LOS_CYCLES))
      los_cnt_r <= los_cnt_r + OW'(1);
  end

  // loss bit, rest of register zero
  always_ff @(posedge CLOCK_I) begin
    if (RST_I)
      line_sig_r <= 8'h00;
    else
      line_sig_r <= {(los_s2_r && los_cnt_r == OW'(LOS_CYCLES)), 7'h00};
  end

  //////////////////////////////////////////////////////////////////////////
  // jitter attenuator status

  always_ff @(posedge CLOCK_I) begin
    if (RST_I)
      dejit_r <= 8'h00;
    else begin
      dejit_r[7] <= DJ_SLOW_I;
      dejit_r[6] <= DJ_FAST_I;
      dejit_r[5] <= (JFIFO_LEVEL_I == LW'(0));
      dejit_r[4] <= (JFIFO_LEVEL_I >= LW'(`JFIFO_FOUR));
      dejit_r[3] <= (JFIFO_LEVEL_I >= LW'(JFIFO_DEPTH / 2));
      dejit_r[2] <= (JFIFO_LEVEL_I >= LW'(JFIFO_DEPTH - `JFIFO_FOUR));
      dejit_r[1] <= (JFIFO_LEVEL_I >= LW'(JFIFO_DEPTH));
      dejit_r[0] <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // assertions

  slip_toggle_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    SLIP_I |=> slip_tog_r != $past(slip_tog_r))
    else $error("slip bit did not toggle");

  slip_dir_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    SLIP_I |=> slip_dir_r == $past(SLIP_REPEAT_I))
    else $error("slip direction not latched");

  phase_hold_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    !frame_tick |=> $stable(phase_low_r))
    else $error("phase word changed off frame tick");

  frame_tog_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    $changed(frm_tog_r) |-> $fell(phase_low_r[7]))
    else $error("frame toggle without falling slot msb");

  alt_rise_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    $rose(alt_flag_r) |-> alt_run_r == 10'd512)
    else $error("pattern flag rose before 512 bits");

  los_rise_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    $rose(line_sig_r[7]) |-> $past(los_cnt_r) == OW'(LOS_CYCLES))
    else $error("loss bit rose too early");

  align_cap_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    TS0_I.valid && TS0_I.is_align |=> align_r == $past(TS0_I.data)
      && $stable(nonalign_r))
    else $error("alignment capture wrong");

  ro_write_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    done && PWRITE_I && idx_of(PADDR_I) == 5'h14 && !TS0_I.valid
      |=> $stable(align_r))
    else $error("write changed a status register");

  fifo_full_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    JFIFO_LEVEL_I == LW'(JFIFO_DEPTH) |=> dejit_r[1] && dejit_r[2]
      && !dejit_r[5])
    else $error("fifo flags wrong when full");
endmodule

// >>> design/e1_rx_status_params.svh
// Purpose: constants for the E1 receive status bank
// Assumes: 25 MHz register clock
// Notes: offsets are register indices; byte address is four times these
//
// What this block does
// - Slip bit 7 of the high phase register toggles on each slip.
// - Slip direction: 1 repeated frame (system fast), 0 lost frame.
// - Frame delay bit is 1 above one frame of buffer delay, else 0.
// - Alternating-pattern flag sets after 512 alternating bits, clears on absence.
// - Alternating-pattern detection tolerates two errors per 512-bit window.
// - Frame toggle bit inverts on each fall of the slot count MSB.
// - Sub-bit delay: bit 2 whole, bit 1 half, bit 0 eighth clock.
// - Bits 7 to 3 of low register hold timeslot offset count.
// - Bits 2 to 0 of low register hold system bit offset count.
// - Slot and bit offsets refresh once every 250 us frame.
// - First alignment-frame bit captured into bit 7 of alignment register.
// - Alignment word bits two to eight captured into bits 6 to 0.
// - Line loss bit rises after 1 ms below threshold, low otherwise.
// - Dejitter slow and fast flags follow period trim by 1/16 UI.
// - Jitter FIFO flags: empty, four full, half, four empty, full.
// - First non-alignment bit captured into bit 7 of its register.
// - Second non-alignment bit into bit 6; far end sends it as one.
// - Third non-alignment bit, remote alarm, into bit 5.
// - National spare bits four to eight into register bits 4 to 0.
`ifndef E1_RX_STATUS_PARAMS_SVH
`define E1_RX_STATUS_PARAMS_SVH
// register indices
`define IDX_SLIP_HIGH 5'h12
`define IDX_PHASE_LOW 5'h13
`define IDX_ALIGN_CAP 5'h14
`define IDX_LINE_SIG 5'h15
`define IDX_DEJITTER 5'h16
`define IDX_NONALIGN 5'h17
`define IDX_LOS_CTRL 5'h1F
// field positions
`define POS_SLIP_TOG 7
`define POS_SLIP_DIR 6
`define POS_FRM_DLY 5
`define POS_ALT_PAT 4
`define POS_FRM_TOG 3
`define POS_LOS 7
// timing
`define CLK_MHZ 25
`define FRAME_US 250
`define LOS_US 1000
`define FRAME_CYC (`FRAME_US * `CLK_MHZ)
`define LOS_CYC (`LOS_US * `CLK_MHZ)
`define ALT_RUN_BITS 512
`define ALT_ERR_MAX 2
`define JFIFO_DEPTH 16
`define JFIFO_FOUR 4
`endif

// >>> design/e1_rx_status_pkg.sv
// Purpose: carrier types for the E1 receive status bank
// Assumes: nothing beyond the params header
// Notes: types only; numbers live in the header
package e1_rx_status_pkg;
  // one sample of the elastic buffer phase
  typedef struct packed {
    logic frame_delay_msb;
    logic [4:0] slot_offset_count;
    logic [2:0] bit_offset_count;
    logic [2:0] sub_bit_delay;
  } phase_t;
  // timeslot-zero byte with its frame kind
  typedef struct packed {
    logic valid;
    logic is_align;
    logic [7:0] data;
  } ts0_t;
  // aux detector states
  typedef enum logic [1:0] {
    ALT_IDLE = 2'b00,
    ALT_RUN = 2'b01,
    ALT_FOUND = 2'b10
  } alt_state_t;
endpackage

// >>> verification/e1_far_end.sv
// Purpose: far-end E1 terminal feeding timeslot-zero bytes and line bits
// Assumes: every call starts after a rising edge of clk_i
// Notes: released lines carry the inverse of the last value; only is_align keeps a stale copy
`timescale 1ns/1ps
module e1_far_end (
  // clock
  input wire logic clk_i,
  // line side toward the framer
  output e1_rx_status_pkg::ts0_t ts0_o,
  output logic bit_o,
  output logic bit_valid_o
);
  //////////////////////////////////////////////////////////////////////////
  // quiet line at time zero
  initial begin
    ts0_o = '0;
    bit_o = 1'b0;
    bit_valid_o = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////
  // one timeslot-zero byte, valid for one cycle
  task automatic send_ts0(input logic al, input logic [7:0] d);
    logic [7:0] b;
    b = d;
    if (!al) b[6] = 1'b1;
    @(posedge clk_i);
    ts0_o <= {1'b1, al, b};
    @(posedge clk_i);
    ts0_o <= {1'b0, al, ~b};
  endtask
  // n bits, alternating or all ones; bits e1 and e2 are flipped
  task automatic send_bits(input int n, input logic alt, input int e1,
                           input int e2);
    logic b;
    for (int i = 0; i < n; i++) begin
      b = (alt ? ~i[0] : 1'b1) ^ (i == e1 || i == e2);
      @(posedge clk_i);
      bit_o <= b;
      bit_valid_o <= 1'b1;
      @(posedge clk_i);
      bit_o <= ~b;
      bit_valid_o <= 1'b0;
    end
  endtask
endmodule

// >>> verification/tb_top.sv
// Purpose: self-checking bench for the E1 receive status bank
// Assumes: zero-wait APB slave, short frame and loss counts
// Notes: expected register images are rebuilt from bench state
`timescale 1ns/1ps
`include "e1_rx_status_params.svh"
module tb_top;
  localparam int FC = 16;
  localparam int LC = 20;
  localparam int JD = 16;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic slip = 1'b0;
  logic slip_rep = 1'b0;
  e1_rx_status_pkg::phase_t phase = '0;
  e1_rx_status_pkg::ts0_t ts0;
  logic rxb;
  logic rxv;
  logic los_below = 1'b0;
  logic los_sel;
  logic dj_slow = 1'b0;
  logic dj_fast = 1'b0;
  logic [4:0] jlvl = 5'h00;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  logic tog = 1'b0, dir = 1'b0, fdm = 1'b0, alt = 1'b0, ftog = 1'b0;
  logic [2:0] sub = 3'h0;
  logic [31:0] q;
  logic er;
  logic [4:0] ix[6] = '{`IDX_SLIP_HIGH, `IDX_PHASE_LOW, `IDX_ALIGN_CAP,
                        `IDX_LINE_SIG, `IDX_DEJITTER, `IDX_NONALIGN};
  int lv[9] = '{0, 3, 4, 7, 8, 11, 12, 15, 16};
  //////////////////////////////////////////////////////////////////////////
  // clock and instances
  always #20 clk = ~clk;
  e1_rx_status_capture #(.FRAME_CYCLES(FC), .LOS_CYCLES(LC),
    .JFIFO_DEPTH(JD)) uut (.CLOCK_I(clk), .RST_I(rst), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .SLIP_I(slip), .SLIP_REPEAT_I(slip_rep),
    .PHASE_I(phase), .RX_BIT_I(rxb), .RX_BIT_VALID_I(rxv), .TS0_I(ts0),
    .LOS_BELOW_I(los_below), .LOS_THRESH_SEL_O(los_sel),
    .DJ_SLOW_I(dj_slow), .DJ_FAST_I(dj_fast), .JFIFO_LEVEL_I(jlvl));
  e1_far_end far (.clk_i(clk), .ts0_o(ts0), .bit_o(rxb),
    .bit_valid_o(rxv));
  //////////////////////////////////////////////////////////////////////////
  // compare, count, and report a mismatch at once
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      fail_count++;
      $display("mismatch at %0t seen %h expected %h", $time, s, x);
    end
  endtask
  // one APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the bench hang guard bounds this wait; it ends when pready is high
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] i, input logic [31:0] x);
    apb(1'b0, {1'b0, i, 2'b00}, 32'h0);
    chk(q, x);
  endtask
  // image of the slip and phase high register
  function automatic logic [31:0] st48();
    return {24'h0, tog, dir, fdm, alt, ftog, sub};
  endfunction
  function automatic logic [31:0] jx(input logic s, input logic f,
                                     input int l);
    return {24'h0, s, f, l == 0, l >= 4, l >= JD / 2, l >= JD - 4,
            l == JD, 1'b0};
  endfunction
  task automatic slip_pulse(input logic rp);
    @(posedge clk);
    slip <= 1'b1;
    slip_rep <= rp;
    @(posedge clk);
    slip <= 1'b0;
    tog = ~tog;
    dir = rp;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // hang guard, far above the roughly 1500 cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      give_verdict();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, {1'b0, ix[i], 2'b00}, 32'hFFFFFFFF);
      // an empty jitter fifo reads back its empty flag
      rd(ix[i], (ix[i] == `IDX_DEJITTER) ? 32'h20 : 32'h0);
    end
    apb(1'b0, 8'h49, 32'h0);
    chk({q[30:0], er}, 32'h1);
    apb(1'b1, {1'b0, `IDX_LOS_CTRL, 2'b00}, 32'h1);
    // the select settles at the write edge; look one edge later
    @(posedge clk);
    chk({31'h0, los_sel}, 32'h1);
    @(posedge clk);
    phase <= '{1'b1, 5'h13, 3'h5, 3'h6};
    fdm = 1'b1;
    sub = 3'h6;
    repeat (2 * FC + 2) @(posedge clk);
    rd(`IDX_PHASE_LOW, 32'h9D);
    rd(`IDX_SLIP_HIGH, st48());
    phase <= '{1'b0, 5'h04, 3'h2, 3'h1};
    fdm = 1'b0;
    sub = 3'h1;
    ftog = 1'b1;
    repeat (2 * FC + 2) @(posedge clk);
    rd(`IDX_PHASE_LOW, 32'h22);
    rd(`IDX_SLIP_HIGH, st48());
    slip_pulse(1'b1);
    rd(`IDX_SLIP_HIGH, st48());
    slip_pulse(1'b0);
    slip_pulse(1'b0);
    rd(`IDX_SLIP_HIGH, st48());
    far.send_ts0(1'b1, 8'h9B);
    far.send_ts0(1'b0, 8'hE5);
    rd(`IDX_ALIGN_CAP, 32'h9B);
    rd(`IDX_NONALIGN, 32'hE5);
    far.send_ts0(1'b0, 8'h0A);
    rd(`IDX_NONALIGN, 32'h4A);
    rd(`IDX_ALIGN_CAP, 32'h9B);
    far.send_ts0(1'b1, 8'h1B);
    rd(`IDX_ALIGN_CAP, 32'h1B);
    rd(`IDX_NONALIGN, 32'h4A);
    los_below <= 1'b1;
    repeat (LC / 2) @(posedge clk);
    rd(`IDX_LINE_SIG, 32'h0);
    repeat (LC) @(posedge clk);
    rd(`IDX_LINE_SIG, 32'h80);
    los_below <= 1'b0;
    repeat (4) @(posedge clk);
    rd(`IDX_LINE_SIG, 32'h0);
    for (int i = 0; i < 9; i++) begin
      jlvl <= 5'(lv[i]);
      dj_slow <= i[0];
      dj_fast <= i[1] & ~i[0];
      rd(`IDX_DEJITTER, jx(i[0], i[1] & ~i[0], lv[i]));
    end
    far.send_bits(600, 1'b1, 200, 450);
    alt = 1'b1;
    rd(`IDX_SLIP_HIGH, st48());
    far.send_bits(16, 1'b0, -1, -1);
    alt = 1'b0;
    rd(`IDX_SLIP_HIGH, st48());
    give_verdict();
  end
endmodule
